// ==== ctu_cfg.svh ====
// Constants of the trigonometric and hyperbolic function unit
`ifndef CTU_CFG_SVH
`define CTU_CFG_SVH

// Data widths: 16-bit registers, two guard bits below and two headroom bits above
`define CTU_DW          16
`define CTU_GUARD       2
`define CTU_IW          20
`define CTU_IDXW        4

// Function field bit positions
`define CTU_FN_ROT      0
`define CTU_FN_SCL      1
`define CTU_FN_HYP      2

// Gain constants, 15 fraction bits (octal 0.46672 and octal 1.15217)
`define CTU_KW          18
`define CTU_K_FRAC      15
`define CTU_K_CIRC      18'h04DBA
`define CTU_K_HYP       18'h09A8F

// Binary angle encoding quadrant steps
`define CTU_ANG_0       16'h0000
`define CTU_ANG_90      16'h4000
`define CTU_ANG_180     16'h8000

// Iteration schedule
`define CTU_CIRC_FIRST  4'h0
`define CTU_HYP_FIRST   4'h1
`define CTU_LAST_IDX    4'hF
`define CTU_HYP_REP_A   4'h4
`define CTU_HYP_REP_B   4'hD

// Saturation limits of a 16-bit result
`define CTU_SAT_POS     16'h7FFF
`define CTU_SAT_NEG     16'h8000
`define CTU_ZERO16      16'h0000

// Reset value of the whole state record
`define CTU_RST_REGS    '0

`endif

// ==== ctu_pkg.sv ====
// Types of the trigonometric and hyperbolic function unit
`include "ctu_cfg.svh"

package ctu_pkg;

  typedef enum logic [1:0] {
    CTU_ST_IDLE  = 2'b00,
    CTU_ST_RUN   = 2'b01,
    CTU_ST_SCALE = 2'b10
  } ctu_state_t;

  typedef enum logic [2:0] {
    CTU_FN_CIRC_VEC     = 3'b000,
    CTU_FN_CIRC_ROT     = 3'b001,
    CTU_FN_CIRC_VEC_SCL = 3'b010,
    CTU_FN_CIRC_ROT_SCL = 3'b011,
    CTU_FN_HYP_VEC      = 3'b100,
    CTU_FN_HYP_ROT      = 3'b101,
    CTU_FN_HYP_VEC_SCL  = 3'b110,
    CTU_FN_HYP_ROT_SCL  = 3'b111
  } ctu_func_t;

  // Operands as read from three consecutive general registers
  typedef struct packed {
    ctu_func_t               func;
    logic [`CTU_DW-1:0]      y;
    logic [`CTU_DW-1:0]      x;
    logic [`CTU_DW-1:0]      w;
  } ctu_req_t;

  // Results for the same three registers
  typedef struct packed {
    logic [`CTU_DW-1:0]      y;
    logic [`CTU_DW-1:0]      x;
    logic [`CTU_DW-1:0]      w;
  } ctu_res_t;

  typedef struct packed {
    ctu_state_t              state;
    ctu_func_t               func;
    logic [`CTU_IW-1:0]      y;
    logic [`CTU_IW-1:0]      x;
    logic [`CTU_DW-1:0]      z;
    logic [`CTU_IDXW-1:0]    idx;
    logic                    rep;
    logic                    busy;
    logic                    done;
    ctu_res_t                res;
  } ctu_regs_t;

endpackage : ctu_pkg

// ==== ctu_angle_rom.sv ====
// Elementary angle table: arctangent in binary angle units, inverse tanh with 13 fraction bits
`include "ctu_cfg.svh"

module ctu_angle_rom
  import ctu_pkg::*;
(
  input  wire logic [`CTU_IDXW-1:0] idx_i,
  input  wire logic                 hyp_i,
  output logic      [`CTU_DW-1:0]   ang_o
);

  logic [`CTU_DW-1:0] circ_ang;
  logic [`CTU_DW-1:0] hyp_ang;

  always_comb begin
    case (idx_i)
      4'h0:    circ_ang = 16'h2000;
      4'h1:    circ_ang = 16'h12E4;
      4'h2:    circ_ang = 16'h09FB;
      4'h3:    circ_ang = 16'h0511;
      4'h4:    circ_ang = 16'h028B;
      4'h5:    circ_ang = 16'h0146;
      4'h6:    circ_ang = 16'h00A3;
      4'h7:    circ_ang = 16'h0051;
      4'h8:    circ_ang = 16'h0029;
      4'h9:    circ_ang = 16'h0014;
      4'hA:    circ_ang = 16'h000A;
      4'hB:    circ_ang = 16'h0005;
      4'hC:    circ_ang = 16'h0003;
      4'hD:    circ_ang = 16'h0001;
      4'hE:    circ_ang = 16'h0001;
      default: circ_ang = 16'h0000;
    endcase
  end

  // Index 0 never occurs in hyperbolic mode, the series diverges there
  always_comb begin
    case (idx_i)
      4'h1:    hyp_ang = 16'h1194;
      4'h2:    hyp_ang = 16'h082C;
      4'h3:    hyp_ang = 16'h0405;
      4'h4:    hyp_ang = 16'h0201;
      4'h5:    hyp_ang = 16'h0100;
      4'h6:    hyp_ang = 16'h0080;
      4'h7:    hyp_ang = 16'h0040;
      4'h8:    hyp_ang = 16'h0020;
      4'h9:    hyp_ang = 16'h0010;
      4'hA:    hyp_ang = 16'h0008;
      4'hB:    hyp_ang = 16'h0004;
      4'hC:    hyp_ang = 16'h0002;
      4'hD:    hyp_ang = 16'h0001;
      4'hE:    hyp_ang = 16'h0001;
      default: hyp_ang = 16'h0000;
    endcase
  end

  assign ang_o = hyp_i ? hyp_ang : circ_ang;

endmodule : ctu_angle_rom

// ==== ctu_unit.sv ====
// Iterative trigonometric and hyperbolic vector/rotate unit of the central processor
//
// Functional notes
// - Code 0: circular vector, raw gain magnitude
// - Code 1: circular rotate, raw gain, angle cleared
// - Code 2: circular vector, true magnitude
// - Code 3: circular rotate, gain corrected
// - Rotate radius on x gives sine, cosine
// - Code 4: hyperbolic vector, raw gain magnitude
// - Code 5: hyperbolic rotate, raw gain, sign-dependent
// - Code 6: hyperbolic vector, gain corrected
// - Code 7: hyperbolic rotate, gain corrected
// - Three consecutive registers: y, x, angle
// - Coordinates 16-bit two's complement, sign point
// - Circular angle is 16-bit binary angle
`include "ctu_cfg.svh"

module ctu_unit
  import ctu_pkg::*;
(
  input  wire logic     CORE_CLK_I,
  input  wire logic     RSTN_I,
  input  wire logic     START_I,
  input  wire ctu_req_t REQ_I,
  output ctu_res_t      RES_O,
  output logic          DONE_O,
  output logic          BUSY_O
);

  ctu_regs_t st_r;
  ctu_regs_t st_nxt;

  // Operand widening and mode decode
  logic [`CTU_IW-1:0]         in_y;
  logic [`CTU_IW-1:0]         in_x;
  logic                       in_hyp;
  logic                       in_rot;
  logic                       cur_hyp;
  logic                       cur_rot;
  logic                       cur_scl;

  // Iteration datapath
  logic [`CTU_IW-1:0]         sh_x;
  logic [`CTU_IW-1:0]         sh_y;
  logic [`CTU_DW-1:0]         step_ang;
  logic                       dir_pos;
  logic [`CTU_IW-1:0]         iter_x;
  logic [`CTU_IW-1:0]         iter_y;
  logic [`CTU_DW-1:0]         iter_z;
  logic                       step_hold;
  logic                       step_last;

  // Gain correction
  logic [`CTU_KW-1:0]         gain_k;
  logic [`CTU_IW+`CTU_KW-1:0] mul_x;
  logic [`CTU_IW+`CTU_KW-1:0] mul_y;
  logic [`CTU_IW+`CTU_KW-1:0] mul_k;
  logic [`CTU_IW+`CTU_KW-1:0] prod_x;
  logic [`CTU_IW+`CTU_KW-1:0] prod_y;
  logic [`CTU_IW-1:0]         fin_x;
  logic [`CTU_IW-1:0]         fin_y;

  // Drop the guard bits; clip rather than wrap when the gain pushes past full scale
  function automatic logic [`CTU_DW-1:0] ctu_sat(input logic [`CTU_IW-1:0] v);
    logic [`CTU_DW-1:0] r;
    r = v[`CTU_DW+`CTU_GUARD-1:`CTU_GUARD];
    if (v[`CTU_IW-1:`CTU_DW+`CTU_GUARD-1] != {3{v[`CTU_IW-1]}}) begin
      r = v[`CTU_IW-1] ? `CTU_SAT_NEG : `CTU_SAT_POS;
    end
    return r;
  endfunction : ctu_sat

  // Sign point sits above bit 14, so the value widens by sign extension
  assign in_y    = {{`CTU_GUARD{REQ_I.y[`CTU_DW-1]}}, REQ_I.y, {`CTU_GUARD{1'b0}}};
  assign in_x    = {{`CTU_GUARD{REQ_I.x[`CTU_DW-1]}}, REQ_I.x, {`CTU_GUARD{1'b0}}};
  // Function code bits: hyperbolic, gain corrected, rotate
  assign in_hyp  = REQ_I.func[`CTU_FN_HYP];
  assign in_rot  = REQ_I.func[`CTU_FN_ROT];

  assign cur_hyp = st_r.func[`CTU_FN_HYP];
  assign cur_rot = st_r.func[`CTU_FN_ROT];
  assign cur_scl = st_r.func[`CTU_FN_SCL];

  ctu_angle_rom u_rom (
    .idx_i (st_r.idx),
    .hyp_i (cur_hyp),
    .ang_o (step_ang)
  );

  // Arithmetic shift keeps negative coordinates negative
  assign sh_x = $signed(st_r.x) >>> st_r.idx;
  assign sh_y = $signed(st_r.y) >>> st_r.idx;

  // Rotate drives the residual angle to zero, vector drives y to zero
  assign dir_pos = cur_rot ? ~st_r.z[`CTU_DW-1] : st_r.y[`CTU_IW-1];

  always_comb begin
    if (cur_hyp) begin
      iter_x = dir_pos ? (st_r.x + sh_y) : (st_r.x - sh_y);
    end else begin
      iter_x = dir_pos ? (st_r.x - sh_y) : (st_r.x + sh_y);
    end
  end

  assign iter_y = dir_pos ? (st_r.y + sh_x) : (st_r.y - sh_x);
  assign iter_z = dir_pos ? (st_r.z - step_ang) : (st_r.z + step_ang);

  // Hyperbolic steps 4 and 13 run twice, otherwise the series does not converge
  assign step_hold = cur_hyp && !st_r.rep &&
                     ((st_r.idx == `CTU_HYP_REP_A) || (st_r.idx == `CTU_HYP_REP_B));
  assign step_last = (st_r.idx == `CTU_LAST_IDX) && !step_hold;

  // Unscaled codes leave the raw iteration gain; scaled codes multiply it back out
  assign gain_k = cur_hyp ? `CTU_K_HYP : `CTU_K_CIRC;
  // Both factors are sign-extended to the product width, so the multiply neither pads nor drops
  assign mul_x  = {{`CTU_KW{st_r.x[`CTU_IW-1]}}, st_r.x};
  assign mul_y  = {{`CTU_KW{st_r.y[`CTU_IW-1]}}, st_r.y};
  assign mul_k  = {{`CTU_IW{gain_k[`CTU_KW-1]}}, gain_k};
  assign prod_x = $signed(mul_x) * $signed(mul_k);
  assign prod_y = $signed(mul_y) * $signed(mul_k);
  // Truncation, not rounding: a corrected result may sit an LSB or two low
  assign fin_x  = cur_scl ? prod_x[`CTU_K_FRAC+`CTU_IW-1:`CTU_K_FRAC] : st_r.x;
  assign fin_y  = cur_scl ? prod_y[`CTU_K_FRAC+`CTU_IW-1:`CTU_K_FRAC] : st_r.y;

  always_comb begin
    st_nxt      = st_r;
    st_nxt.done = 1'b0;
    case (st_r.state)
      CTU_ST_IDLE: begin
        // A start while busy cannot happen here; all eight codes are legal
        if (START_I) begin
          st_nxt.state = CTU_ST_RUN;
          st_nxt.func  = REQ_I.func;
          st_nxt.busy  = 1'b1;
          st_nxt.rep   = 1'b0;
          st_nxt.x     = in_x;
          st_nxt.y     = in_y;
          st_nxt.idx   = in_hyp ? `CTU_HYP_FIRST : `CTU_CIRC_FIRST;
          if (in_hyp) begin
            // Hyperbolic vector starts from zero angle, rotate from w
            st_nxt.z = in_rot ? REQ_I.w : `CTU_ANG_0;
          end else if (in_rot) begin
            // Fold the second and third quadrants by a quarter turn first
            case (REQ_I.w[`CTU_DW-1:`CTU_DW-2])
              2'b01: begin
                st_nxt.x = -in_y;
                st_nxt.y = in_x;
                st_nxt.z = REQ_I.w - `CTU_ANG_90;
              end
              2'b10: begin
                st_nxt.x = in_y;
                st_nxt.y = -in_x;
                st_nxt.z = REQ_I.w + `CTU_ANG_90;
              end
              default: begin
                st_nxt.z = REQ_I.w;
              end
            endcase
          end else begin
            // A vector in the left half plane is flipped; 180 degrees reads negative
            if (in_x[`CTU_IW-1]) begin
              st_nxt.x = -in_x;
              st_nxt.y = -in_y;
              st_nxt.z = `CTU_ANG_180;
            end else begin
              st_nxt.z = `CTU_ANG_0;
            end
          end
        end
      end
      CTU_ST_RUN: begin
        st_nxt.x = iter_x;
        st_nxt.y = iter_y;
        st_nxt.z = iter_z;
        // A repeated hyperbolic step keeps its index for one more pass
        if (step_hold) begin
          st_nxt.rep = 1'b1;
        end else begin
          st_nxt.rep = 1'b0;
          st_nxt.idx = st_r.idx + 4'h1;
        end
        if (step_last) begin
          st_nxt.state = CTU_ST_SCALE;
          st_nxt.idx   = st_r.idx;
        end
      end
      CTU_ST_SCALE: begin
        // All three registers update on the same edge as the done pulse
        st_nxt.res.x = ctu_sat(fin_x);
        st_nxt.res.y = cur_rot ? ctu_sat(fin_y) : `CTU_ZERO16;
        st_nxt.res.w = cur_rot ? `CTU_ZERO16 : st_r.z;
        st_nxt.done  = 1'b1;
        st_nxt.busy  = 1'b0;
        st_nxt.state = CTU_ST_IDLE;
      end
      default: begin
        // An unused state code falls back to the reset record
        st_nxt = `CTU_RST_REGS;
      end
    endcase
  end

  // Reset clears the results as well, so software never reads a stale record
  always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      st_r <= `CTU_RST_REGS;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs are taken straight from the state record flops
  assign RES_O  = st_r.res;
  assign DONE_O = st_r.done;
  assign BUSY_O = st_r.busy;

endmodule : ctu_unit

// ==== ctu_unit_assertions.sv ====
// Port checker of the trigonometric and hyperbolic unit
module ctu_unit_chk
  import ctu_pkg::*;
(
  input wire logic     CORE_CLK_I,
  input wire logic     RSTN_I,
  input wire logic     START_I,
  input wire ctu_req_t REQ_I,
  input wire ctu_res_t RES_O,
  input wire logic     DONE_O,
  input wire logic     BUSY_O
);
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!RSTN_I);
  logic      take;
  ctu_func_t fn_r;
  assign take = START_I && !BUSY_O;
  // Code of the run in flight, so result checks know which register must be cleared
  always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) fn_r <= CTU_FN_CIRC_VEC;
    else if (take) fn_r <= REQ_I.func;
  end
  AST_CIRC_LAT: assert property (take && !REQ_I.func[2] |-> ##17 !DONE_O ##1 DONE_O)
    else $error("circular result not on time");
  AST_HYP_LAT: assert property (take && REQ_I.func[2] |-> ##18 !DONE_O ##1 DONE_O)
    else $error("hyperbolic result not on time");
  AST_BUSY_RUN: assert property (take |=> BUSY_O [*8])
    else $error("busy not held after start");
  AST_DONE_PULSE: assert property (DONE_O |=> !DONE_O)
    else $error("done longer than one cycle");
  AST_DONE_IDLE: assert property (DONE_O |-> !BUSY_O)
    else $error("busy while done");
  AST_BUSY_END: assert property ($fell(BUSY_O) |-> DONE_O)
    else $error("busy ended without done");
  AST_RES_HOLD: assert property (!DONE_O |-> $stable(RES_O))
    else $error("results changed outside done");
  AST_ROT_W: assert property (DONE_O && fn_r[0] |-> RES_O.w == 16'h0000)
    else $error("rotate left angle nonzero");
  AST_VEC_Y: assert property (DONE_O && !fn_r[0] |-> RES_O.y == 16'h0000)
    else $error("vector left y nonzero");
  COV_CIRC: cover property (take && !REQ_I.func[2]);
  COV_HYP: cover property (take && REQ_I.func[2]);
  COV_B2B: cover property (DONE_O && START_I);
endmodule : ctu_unit_chk

bind ctu_unit ctu_unit_chk i_chk (
  .CORE_CLK_I(CORE_CLK_I),
  .RSTN_I    (RSTN_I),
  .START_I   (START_I),
  .REQ_I     (REQ_I),
  .RES_O     (RES_O),
  .DONE_O    (DONE_O),
  .BUSY_O    (BUSY_O)
);

// ==== ctu_gpr_model.sv ====
// General register file and decode partner feeding the function unit
module ctu_gpr_model
  import ctu_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rstn_i,
  input  wire logic       go_i,
  input  wire ctu_func_t  func_i,
  input  wire logic [3:0] ra_i,
  input  wire logic       done_i,
  input  wire ctu_res_t   res_i,
  output logic            start_o,
  output ctu_req_t        req_o
);
  logic [15:0] gpr [16];
  // Operands are scrambled between requests so stale values cannot pass for a match
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      start_o <= 1'b0;
      req_o   <= '0;
    end else begin
      start_o <= go_i;
      req_o   <= go_i ? ctu_req_t'({func_i, gpr[ra_i], gpr[ra_i + 4'h1], gpr[ra_i + 4'h2]}) : ~req_o;
      if (done_i) begin
        gpr[ra_i]        <= res_i.y;
        gpr[ra_i + 4'h1] <= res_i.x;
        gpr[ra_i + 4'h2] <= res_i.w;
      end
    end
  end
endmodule : ctu_gpr_model

// ==== testbench.sv ====
// Self-checking bench of the trigonometric and hyperbolic unit
`define CHK(n, e, g, t) begin checks++; \
  if ($isunknown(g) || ((e) - int'($signed(g)) > (t)) || (int'($signed(g)) - (e) > (t))) begin \
    err_count++; $display("Error %s exp %0d got %0d", n, e, $signed(g)); end end
module testbench
  import ctu_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {ctu_func_t f; logic [15:0] y, x, w; int ey, ex, ew;} ctu_row_t;
  localparam int TOL = 12;
  logic       clk, rstn, go, start, done, busy;
  ctu_func_t  func;
  logic [3:0] ra;
  ctu_req_t   req;
  ctu_res_t   res;
  int         err_count, checks;
  // Small inputs keep hyperbolic vector |y/x| below one
  ctu_row_t rows [15] = '{
    '{CTU_FN_CIRC_VEC,     16'h1800, 16'h2000, 16'h0000, 0, 16863, 6712},
    '{CTU_FN_CIRC_VEC_SCL, 16'h1800, 16'h2000, 16'h0000, 0, 10240, 6712},
    '{CTU_FN_CIRC_ROT,     16'h0000, 16'h4DBA, 16'h1555, 16383, 28378, 0},
    '{CTU_FN_CIRC_ROT,     16'h0000, 16'h4DBA, 16'hC000, -32768, 0, 0},
    '{CTU_FN_CIRC_ROT_SCL, 16'h0000, 16'h4000, 16'h2000, 11585, 11585, 0},
    '{CTU_FN_HYP_VEC,      16'h0800, 16'h1000, 16'h0000, 0, 2938, 4500},
    '{CTU_FN_HYP_VEC_SCL,  16'h0800, 16'h1000, 16'h0000, 0, 3547, 4500},
    '{CTU_FN_HYP_ROT,      16'h0000, 16'h2000, 16'h1000, 3535, 7650, 0},
    '{CTU_FN_HYP_ROT,      16'h0000, 16'h2000, 16'hF000, -3535, 7650, 0},
    '{CTU_FN_HYP_ROT_SCL,  16'h0000, 16'h2000, 16'h1000, 4269, 9237, 0},
    '{CTU_FN_HYP_VEC_SCL,  16'h1000, 16'h3000, 16'h0000, 0, 11585, 2839},
    '{CTU_FN_HYP_ROT_SCL,  16'h2000, 16'h2000, 16'h1000, 13506, 13506, 0},
    '{CTU_FN_CIRC_ROT_SCL, 16'h0000, 16'h4000, 16'h6000, 11585, -11585, 0},
    '{CTU_FN_CIRC_ROT_SCL, 16'h0000, 16'h4000, 16'hA000, -11585, -11585, 0},
    '{CTU_FN_CIRC_VEC_SCL, 16'h1800, 16'hE000, 16'h0000, 0, 10240, 26056}};
  ctu_unit i_dut (.CORE_CLK_I(clk), .RSTN_I(rstn), .START_I(start), .REQ_I(req), .RES_O(res),
                  .DONE_O(done), .BUSY_O(busy));
  ctu_gpr_model i_gpr (.clk_i(clk), .rstn_i(rstn), .go_i(go), .func_i(func), .ra_i(ra),
                       .done_i(done), .res_i(res), .start_o(start), .req_o(req));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic stop_test();
    if (err_count == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : stop_test
  task automatic wait_done();
    int n;
    n = 0;
    // Always pass one edge first: a done pulse still showing from the last run is not this one's
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (n < 40 && done !== 1'b1);
    `CHK("done", 1, {1'b0, done}, 0)
  endtask : wait_done
  task load(int a, logic [15:0] y, logic [15:0] x, logic [15:0] w, ctu_func_t f);
    @(posedge clk);
    i_gpr.gpr[a] <= y;
    i_gpr.gpr[a + 1] <= x;
    i_gpr.gpr[a + 2] <= w;
    func <= f;
    ra <= a[3:0];
    go <= 1'b1;
  endtask : load
  initial begin
    rstn = 1'b0;
    go = 1'b0;
    func = CTU_FN_CIRC_VEC;
    ra = 4'h0;
    err_count = 0;
    checks = 0;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    for (int i = 0; i < 15; i++) begin
      load(i % 8, rows[i].y, rows[i].x, rows[i].w, rows[i].f);
      @(posedge clk);
      go <= 1'b0;
      wait_done();
      @(posedge clk);
      #1;
      `CHK("y", rows[i].ey, i_gpr.gpr[i % 8], TOL)
      `CHK("x", rows[i].ex, i_gpr.gpr[i % 8 + 1], TOL)
      `CHK("w", rows[i].ew, i_gpr.gpr[i % 8 + 2], TOL)
    end
    // Start held high: a request while busy is dropped, the one in the done cycle is taken
    load(0, 16'h1800, 16'h2000, 16'h0000, CTU_FN_CIRC_VEC);
    repeat (3) @(posedge clk);
    func <= CTU_FN_HYP_VEC;
    wait_done();
    `CHK("refused x", 16863, res.x, TOL)
    `CHK("refused y", 0, res.y, 0)
    @(posedge clk);
    go <= 1'b0;
    wait_done();
    `CHK("b2b x", 4488, res.x, TOL)
    `CHK("b2b w", 7970, res.w, TOL)
    load(3, 16'h0000, 16'h4000, 16'h2000, CTU_FN_CIRC_ROT);
    @(posedge clk);
    go <= 1'b0;
    repeat (6) @(posedge clk);
    rstn <= 1'b0;
    #1;
    `CHK("reset", 0, |{res, done, busy}, 0)
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    // The unit must come back idle and take a fresh request after a reset in mid-run
    load(4, 16'h0000, 16'h4DBA, 16'h1555, CTU_FN_CIRC_ROT);
    @(posedge clk);
    go <= 1'b0;
    wait_done();
    `CHK("reset y", 16383, res.y, TOL)
    `CHK("reset x", 28378, res.x, TOL)
    stop_test();
  end
  initial begin
    #20000;
    err_count++;
    stop_test();
  end
endmodule : testbench
